// [dig_defines.svh]
`ifndef DIG_DEFINES_SVH
`define DIG_DEFINES_SVH

// register subaddresses
`define DIG_SYNC_CONTROL_ADDR 8'h0e
`define DIG_LOOP_CLOCK_CONTROL_ADDR 8'h0f
`define DIG_LINE_PERIOD_LOW_ADDR 8'h10
`define DIG_LINE_PERIOD_HIGH_ADDR 8'h11
`define DIG_FRAME_PERIOD_LOW_ADDR 8'h12
`define DIG_FRAME_PERIOD_HIGH_ADDR 8'h13
`define DIG_LIVE_STEP_BYTE0_ADDR 8'h14
`define DIG_LIVE_STEP_BYTE1_ADDR 8'h15
`define DIG_LIVE_STEP_BYTE2_ADDR 8'h16
`define DIG_LIVE_STEP_BYTE3_ADDR 8'h17
`define DIG_LIVE_STEP_BYTE4_ADDR 8'h18
`define DIG_SYNC_PRESENCE_STATUS_ADDR 8'h19
`define DIG_CLAMP_CONTROL_ADDR 8'h20
`define DIG_CLAMP_BEGIN_LOW_ADDR 8'h21
`define DIG_CLAMP_BEGIN_HIGH_ADDR 8'h22
`define DIG_CLAMP_END_LOW_ADDR 8'h23
`define DIG_CLAMP_END_HIGH_ADDR 8'h24
`define DIG_CHAN1_CLAMP_LEVEL_ADDR 8'h25
`define DIG_CHAN1_COARSE_GAIN_ADDR 8'h26
`define DIG_CHAN1_FINE_GAIN_ADDR 8'h27
`define DIG_CHAN2_CLAMP_LEVEL_ADDR 8'h28

// field positions
`define DIG_PHASE_DETECTOR_OFF_BIT 5
`define DIG_CONVERTER_CLOCK_SOURCE_BIT 4
`define DIG_SECOND_ADC_CLOCK_INVERT_BIT 3
`define DIG_SECOND_ADC_CLOCK_HALVE_BIT 2
`define DIG_SYNTH_CLOCK_OUT_INVERT_BIT 1
`define DIG_SYNTH_CLOCK_OUT_HALVE_BIT 0
`define DIG_LINE_SYNC_POLARITY_BIT 3
`define DIG_CLAMP_TIMING_SOURCE_BIT 6

// reset values
`define DIG_LOOP_CLOCK_CONTROL_RST 8'h20
`define DIG_SYNC_CONTROL_RST 8'h00
`define DIG_CLAMP_CONTROL_RST 8'h2a
`define DIG_CLAMP_BEGIN_RST 12'h002
`define DIG_CLAMP_END_RST 12'h040
`define DIG_CLAMP_LEVEL_RST 8'h80
`define DIG_COARSE_GAIN_RST 6'h20
`define DIG_FINE_GAIN_RST 5'h10

// loop and timing constants
`define DIG_NOMINAL_STEP 33'h0ba2e8a16
`define DIG_LOOP_GAIN 33'h000010000
`define DIG_LINE_TOTAL 12'h400
`define DIG_NOSYNC_CYCLES 12'hfff
`define DIG_DEVICE_ADDR 7'h20

`endif

// [dig_pkg.sv]
package dig_pkg;
`include "dig_defines.svh"

   typedef enum logic [3:0] {
      DIG_IDLE, DIG_ADDR, DIG_AACK, DIG_SUB, DIG_SACK, DIG_WDATA, DIG_WACK, DIG_RDATA, DIG_MACK
   } dig_i2c_t;

   typedef struct packed {
      logic scl_q;
      logic sda_q;
      dig_i2c_t i2c;
      logic [3:0] bits;
      logic [7:0] shift;
      logic [7:0] sub;
      logic nack;
      logic sda_oe;
      logic [7:0] loop_ctl;
      logic [7:0] sync_ctl;
      logic [7:0] clamp_ctl;
      logic [11:0] clamp_begin;
      logic [11:0] clamp_end;
      logic [7:0] c1_level;
      logic [7:0] c2_level;
      logic [5:0] c1_coarse;
      logic [4:0] c1_fine;
      logic hs_prev;
      logic vs_prev;
      logic [11:0] pix;
      logic [11:0] lines;
      logic [11:0] line_period;
      logic [11:0] frame_period;
      logic [11:0] nosync_cnt;
      logic missing;
      logic [11:0] snap_line;
      logic [11:0] snap_frame;
      logic [32:0] snap_step;
      logic snap_missing;
      logic [32:0] step;
      logic [32:0] acc;
      logic [11:0] fb;
      logic synth;
      logic prim;
      logic half2;
      logic half3;
      logic second;
      logic synth_out;
      logic clamp_int;
      logic [2:0] clamp;
   } dig_state_t;

endpackage : dig_pkg

// [dig_regs.sv]
`timescale 1ns/1ps
// What this block does
// - phase detector off holds the synthesizer step at nominal; on, it tracks line sync
// - converter clock source bit picks synthesized clock (0) or external clock pin (1)
// - second converter clock equals primary clock, or its inverse when invert bit set
// - second converter clock halve bit divides its source by two
// - synthesizer clock output inverted when its invert bit is set
// - synthesizer clock output halve bit divides it by two
// - count pixel clocks between active line syncs, 12 bits, load at each edge
// - host reads of live counters never return torn values
// - count lines between active frame syncs, 12 bits, load at each frame edge
// - expose current 33-bit step over five read-only bytes, bit 32 in fifth
// - status bit reads 0 with line sync present, 1 when missing
// - clamp timing source bit picks internal pulse (0) or external input (1)
// - per-channel clamp enable bit, default on
// - per-channel clamp range bit, 1 middle, 0 bottom default
// - 12-bit clamp begin pixel, reset 0x2, unused with external timing
// - 12-bit clamp end pixel, reset 0x40, ignored with external timing
// - 8-bit clamp level for channels 1 and 2 only, reset 0x80
// - 6-bit coarse gain in bits 5..0, reset 0x20
// - 5-bit fine gain in bits 4..0, reset 0x10
// - line sync active edge follows polarity bit: 0 positive, 1 negative
module dig_regs
   import dig_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic i2c_scl_in,
   input wire logic i2c_sda_in,
   output logic i2c_sda_out,
   output logic i2c_sda_oe_out,
   input wire logic line_sync_in,
   input wire logic frame_sync_in,
   input wire logic external_converter_clock_in,
   input wire logic ext_clamp_in,
   output logic primary_converter_clock_out,
   output logic second_converter_clock_out,
   output logic synth_clock_out,
   output logic [2:0] chan_clamp_out,
   output logic [2:0] chan_clamp_range_out,
   output logic [7:0] chan1_clamp_level_value_out,
   output logic [5:0] chan1_coarse_gain_value_out,
   output logic [4:0] chan1_fine_gain_value_out,
   output logic [7:0] chan2_clamp_level_value_out
);

   dig_state_t q;
   dig_state_t n;

   logic scl_rise;
   logic scl_fall;
   logic i2c_start;
   logic i2c_stop;
   logic hs_lvl;
   logic hs_edge;
   logic vs_edge;
   logic synth_rise;
   logic prim_rise;

   // read mux; counters come from the snapshot taken when the read began
   function automatic logic [7:0] rd_byte(input dig_state_t s, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         `DIG_SYNC_CONTROL_ADDR: r = s.sync_ctl;
         `DIG_LOOP_CLOCK_CONTROL_ADDR: r = s.loop_ctl;
         `DIG_LINE_PERIOD_LOW_ADDR: r = s.snap_line[7:0];
         `DIG_LINE_PERIOD_HIGH_ADDR: r = {4'h0, s.snap_line[11:8]};
         `DIG_FRAME_PERIOD_LOW_ADDR: r = s.snap_frame[7:0];
         `DIG_FRAME_PERIOD_HIGH_ADDR: r = {4'h0, s.snap_frame[11:8]};
         `DIG_LIVE_STEP_BYTE0_ADDR: r = s.snap_step[7:0];
         `DIG_LIVE_STEP_BYTE1_ADDR: r = s.snap_step[15:8];
         `DIG_LIVE_STEP_BYTE2_ADDR: r = s.snap_step[23:16];
         `DIG_LIVE_STEP_BYTE3_ADDR: r = s.snap_step[31:24];
         `DIG_LIVE_STEP_BYTE4_ADDR: r = {7'h00, s.snap_step[32]};
         `DIG_SYNC_PRESENCE_STATUS_ADDR: r = {7'h00, s.snap_missing};
         `DIG_CLAMP_CONTROL_ADDR: r = {1'b0, s.clamp_ctl[6:0]};
         `DIG_CLAMP_BEGIN_LOW_ADDR: r = s.clamp_begin[7:0];
         `DIG_CLAMP_BEGIN_HIGH_ADDR: r = {4'h0, s.clamp_begin[11:8]};
         `DIG_CLAMP_END_LOW_ADDR: r = s.clamp_end[7:0];
         `DIG_CLAMP_END_HIGH_ADDR: r = {4'h0, s.clamp_end[11:8]};
         `DIG_CHAN1_CLAMP_LEVEL_ADDR: r = s.c1_level;
         `DIG_CHAN1_COARSE_GAIN_ADDR: r = {2'h0, s.c1_coarse};
         `DIG_CHAN1_FINE_GAIN_ADDR: r = {3'h0, s.c1_fine};
         `DIG_CHAN2_CLAMP_LEVEL_ADDR: r = s.c2_level;
         default: r = 8'h00;
      endcase
      return r;
   endfunction : rd_byte

   assign scl_rise = i2c_scl_in & ~q.scl_q;
   assign scl_fall = ~i2c_scl_in & q.scl_q;
   assign i2c_start = i2c_scl_in & q.scl_q & q.sda_q & ~i2c_sda_in;
   assign i2c_stop = i2c_scl_in & q.scl_q & ~q.sda_q & i2c_sda_in;
   assign hs_lvl = line_sync_in ^ q.sync_ctl[`DIG_LINE_SYNC_POLARITY_BIT];
   assign hs_edge = hs_lvl & ~q.hs_prev;
   assign vs_edge = frame_sync_in & ~q.vs_prev;

   always_comb begin
      n = q;
      n.scl_q = i2c_scl_in;
      n.sda_q = i2c_sda_in;

      // serial slave
      if (i2c_start) begin
         n.i2c = DIG_ADDR;
         n.bits = 4'h0;
         n.sda_oe = 1'b0;
      end else if (i2c_stop) begin
         n.i2c = DIG_IDLE;
         n.sda_oe = 1'b0;
      end else if (scl_rise) begin
         unique case (q.i2c)
            DIG_ADDR, DIG_SUB, DIG_WDATA: begin
               n.shift = {q.shift[6:0], i2c_sda_in};
               n.bits = q.bits + 4'h1;
            end
            DIG_RDATA: n.bits = q.bits + 4'h1;
            DIG_MACK: n.nack = i2c_sda_in;
            default: n.bits = q.bits;
         endcase
      end else if (scl_fall) begin
         unique case (q.i2c)
            DIG_ADDR: begin
               if (q.bits == 4'h8) begin
                  if (q.shift[7:1] == `DIG_DEVICE_ADDR) begin
                     n.sda_oe = 1'b1;
                     n.nack = q.shift[0];
                     n.i2c = DIG_AACK;
                     if (q.shift[0]) begin
                        n.snap_line = q.line_period;
                        n.snap_frame = q.frame_period;
                        n.snap_step = q.step;
                        n.snap_missing = q.missing;
                     end
                  end else begin
                     n.i2c = DIG_IDLE;
                  end
               end
            end
            DIG_AACK: begin
               n.bits = 4'h0;
               if (q.nack) begin
                  n.i2c = DIG_RDATA;
                  n.shift = rd_byte(q, q.sub);
                  n.sda_oe = ~n.shift[7];
                  n.nack = 1'b0;
               end else begin
                  n.i2c = DIG_SUB;
                  n.sda_oe = 1'b0;
               end
            end
            DIG_SUB: begin
               if (q.bits == 4'h8) begin
                  n.sub = q.shift;
                  n.sda_oe = 1'b1;
                  n.i2c = DIG_SACK;
               end
            end
            DIG_SACK, DIG_WACK: begin
               n.sda_oe = 1'b0;
               n.bits = 4'h0;
               n.i2c = DIG_WDATA;
            end
            DIG_WDATA: begin
               if (q.bits == 4'h8) begin
                  n.sda_oe = 1'b1;
                  n.i2c = DIG_WACK;
                  n.sub = q.sub + 8'h01;
                  case (q.sub)
                     `DIG_SYNC_CONTROL_ADDR: n.sync_ctl = q.shift;
                     `DIG_LOOP_CLOCK_CONTROL_ADDR: n.loop_ctl = {2'h0, q.shift[5:0]};
                     `DIG_CLAMP_CONTROL_ADDR: n.clamp_ctl = {1'b0, q.shift[6:0]};
                     `DIG_CLAMP_BEGIN_LOW_ADDR: n.clamp_begin[7:0] = q.shift;
                     `DIG_CLAMP_BEGIN_HIGH_ADDR: n.clamp_begin[11:8] = q.shift[3:0];
                     `DIG_CLAMP_END_LOW_ADDR: n.clamp_end[7:0] = q.shift;
                     `DIG_CLAMP_END_HIGH_ADDR: n.clamp_end[11:8] = q.shift[3:0];
                     `DIG_CHAN1_CLAMP_LEVEL_ADDR: n.c1_level = q.shift;
                     `DIG_CHAN1_COARSE_GAIN_ADDR: n.c1_coarse = q.shift[5:0];
                     `DIG_CHAN1_FINE_GAIN_ADDR: n.c1_fine = q.shift[4:0];
                     `DIG_CHAN2_CLAMP_LEVEL_ADDR: n.c2_level = q.shift;
                     default: n.sub = q.sub + 8'h01;
                  endcase
               end
            end
            DIG_RDATA: begin
               if (q.bits == 4'h8) begin
                  n.sda_oe = 1'b0;
                  n.i2c = DIG_MACK;
                  n.sub = q.sub + 8'h01;
               end else begin
                  n.shift = {q.shift[6:0], 1'b0};
                  n.sda_oe = ~q.shift[6];
               end
            end
            DIG_MACK: begin
               n.bits = 4'h0;
               if (q.nack) begin
                  n.i2c = DIG_IDLE;
               end else begin
                  n.i2c = DIG_RDATA;
                  n.shift = rd_byte(q, q.sub);
                  n.sda_oe = ~n.shift[7];
               end
            end
            DIG_IDLE: n.sda_oe = 1'b0;
         endcase
      end

      // line and frame measurement
      n.hs_prev = hs_lvl;
      n.vs_prev = frame_sync_in;
      if (hs_edge) begin
         n.line_period = q.pix + 12'h001;
         n.pix = 12'h000;
         n.lines = q.lines + 12'h001;
         n.nosync_cnt = 12'h000;
         n.missing = 1'b0;
      end else begin
         n.pix = q.pix + 12'h001;
         if (q.nosync_cnt == `DIG_NOSYNC_CYCLES) begin
            n.missing = 1'b1;
         end else begin
            n.nosync_cnt = q.nosync_cnt + 12'h001;
         end
      end
      if (vs_edge) begin
         n.frame_period = n.lines;
         n.lines = 12'h000;
      end

      // synthesizer loop
      synth_rise = 1'b0;
      n.acc = q.acc + q.step;
      n.synth = n.acc[32];
      synth_rise = n.synth & ~q.synth;
      n.fb = hs_edge ? 12'h000 : q.fb + {11'h000, synth_rise};
      if (q.loop_ctl[`DIG_PHASE_DETECTOR_OFF_BIT]) begin
         n.step = `DIG_NOMINAL_STEP;
      end else if (hs_edge && (q.fb > `DIG_LINE_TOTAL)) begin
         n.step = q.step - `DIG_LOOP_GAIN;
      end else if (hs_edge && (q.fb < `DIG_LINE_TOTAL)) begin
         n.step = q.step + `DIG_LOOP_GAIN;
      end
      n.half3 = q.half3 ^ synth_rise;
      n.synth_out = (q.loop_ctl[`DIG_SYNTH_CLOCK_OUT_HALVE_BIT] ? n.half3 : n.synth)
                    ^ q.loop_ctl[`DIG_SYNTH_CLOCK_OUT_INVERT_BIT];
      n.prim = q.loop_ctl[`DIG_CONVERTER_CLOCK_SOURCE_BIT] ? external_converter_clock_in : n.synth;
      prim_rise = n.prim & ~q.prim;
      n.half2 = q.half2 ^ prim_rise;
      n.second = (q.loop_ctl[`DIG_SECOND_ADC_CLOCK_HALVE_BIT] ? n.half2 : n.prim)
                 ^ q.loop_ctl[`DIG_SECOND_ADC_CLOCK_INVERT_BIT];

      // clamp timing
      if (n.pix == q.clamp_begin) begin
         n.clamp_int = 1'b1;
      end else if (n.pix == q.clamp_end) begin
         n.clamp_int = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
         n.clamp[i] = q.clamp_ctl[5 - 2 * i] &
                      (q.clamp_ctl[`DIG_CLAMP_TIMING_SOURCE_BIT] ? ext_clamp_in : n.clamp_int);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         q <= '0;
         q.scl_q <= 1'b1;
         q.sda_q <= 1'b1;
         q.i2c <= DIG_IDLE;
         q.loop_ctl <= `DIG_LOOP_CLOCK_CONTROL_RST;
         q.sync_ctl <= `DIG_SYNC_CONTROL_RST;
         q.clamp_ctl <= `DIG_CLAMP_CONTROL_RST;
         q.clamp_begin <= `DIG_CLAMP_BEGIN_RST;
         q.clamp_end <= `DIG_CLAMP_END_RST;
         q.c1_level <= `DIG_CLAMP_LEVEL_RST;
         q.c2_level <= `DIG_CLAMP_LEVEL_RST;
         q.c1_coarse <= `DIG_COARSE_GAIN_RST;
         q.c1_fine <= `DIG_FINE_GAIN_RST;
         q.missing <= 1'b1;
         q.snap_missing <= 1'b1;
         q.step <= `DIG_NOMINAL_STEP;
      end else begin
         q <= n;
      end
   end

   assign i2c_sda_out = 1'b0;
   assign i2c_sda_oe_out = q.sda_oe;
   assign primary_converter_clock_out = q.prim;
   assign second_converter_clock_out = q.second;
   assign synth_clock_out = q.synth_out;
   assign chan_clamp_out = q.clamp;
   assign chan_clamp_range_out = {q.clamp_ctl[0], q.clamp_ctl[2], q.clamp_ctl[4]};
   assign chan1_clamp_level_value_out = q.c1_level;
   assign chan1_coarse_gain_value_out = q.c1_coarse;
   assign chan1_fine_gain_value_out = q.c1_fine;
   assign chan2_clamp_level_value_out = q.c2_level;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   sequence hs_seen_s;
      hs_edge;
   endsequence
   sequence period_loaded_s;
      ##1 q.line_period == $past(q.pix) + 12'h001;
   endsequence

   pfd_hold_a: assert property (q.loop_ctl[5] |=> q.step == `DIG_NOMINAL_STEP)
      else $error("step left nominal while phase detector off");
   clk_source_a: assert property (q.loop_ctl[4] ##1 q.loop_ctl[4] |->
      primary_converter_clock_out == $past(external_converter_clock_in))
      else $error("primary clock not from external pin");
   second_inv_a: assert property (!q.loop_ctl[2] && $past(!q.loop_ctl[2]) && $past(q.loop_ctl[3]) |->
      second_converter_clock_out != primary_converter_clock_out)
      else $error("second clock not inverse of primary");
   line_period_a: assert property (hs_seen_s |-> period_loaded_s)
      else $error("line period not loaded at sync edge");
   frame_period_a: assert property (vs_edge && !hs_edge |=> q.frame_period == $past(q.lines))
      else $error("frame period not loaded at frame edge");
   sync_present_a: assert property (hs_edge |=> !q.missing ##1 (q.missing == 1'b0) [*2])
      else $error("missing flag set right after sync edge");
   clamp_begin_a: assert property (!q.clamp_ctl[6] && q.clamp_ctl[5] && n.pix == q.clamp_begin
      |=> chan_clamp_out[0])
      else $error("internal clamp did not start at begin pixel");
   clamp_ext_a: assert property (q.clamp_ctl[6] && q.clamp_ctl[3] |=>
      chan_clamp_out[1] == $past(ext_clamp_in))
      else $error("external clamp not followed");
   snap_hold_a: assert property (q.i2c == DIG_RDATA && !i2c_start |=>
      $stable(q.snap_line) && $stable(q.snap_step))
      else $error("snapshot changed during read");
   chan1_enable_a: assert property (!q.clamp_ctl[5] |=> !chan_clamp_out[0])
      else $error("channel 1 clamped while disabled");
   chan3_enable_a: assert property (!q.clamp_ctl[1] |=> !chan_clamp_out[2])
      else $error("channel 3 clamped while disabled");
   clamp_end_a: assert property (!q.clamp_ctl[6] && q.clamp_ctl[5] && n.pix == q.clamp_end
      && n.pix != q.clamp_begin |=> !chan_clamp_out[0])
      else $error("internal clamp did not stop at end pixel");
   synth_plain_a: assert property ($past(q.loop_ctl[1:0]) == 2'b00 |-> synth_clock_out == q.synth)
      else $error("synth clock output not plain");
   synth_inv_a: assert property ($past(q.loop_ctl[1:0]) == 2'b10 |-> synth_clock_out != q.synth)
      else $error("synth clock output not inverted");
   synth_halve_a: assert property ($past(q.loop_ctl[1:0]) == 2'b01 && $past(q.loop_ctl[1:0], 2) == 2'b01
      && $changed(synth_clock_out) |-> $past(synth_rise))
      else $error("halved synth clock toggled without a source rise");
   second_plain_a: assert property ($past(q.loop_ctl[3:2]) == 2'b00 |->
      second_converter_clock_out == primary_converter_clock_out)
      else $error("second clock differs from primary");
   second_halve_a: assert property ($past(q.loop_ctl[3:2]) == 2'b01 && $past(q.loop_ctl[3:2], 2) == 2'b01
      && $changed(second_converter_clock_out) |-> $past(prim_rise))
      else $error("halved second clock toggled without a primary rise");
   missing_set_a: assert property (q.nosync_cnt == `DIG_NOSYNC_CYCLES && !hs_edge |=> q.missing)
      else $error("missing flag not set after sync timeout");
   gain_reset_a: assert property ($fell(rst_in) |-> chan1_clamp_level_value_out == `DIG_CLAMP_LEVEL_RST
      && chan1_coarse_gain_value_out == `DIG_COARSE_GAIN_RST && chan1_fine_gain_value_out == `DIG_FINE_GAIN_RST)
      else $error("channel settings not at reset values");

endmodule : dig_regs

// [dig_host.sv]
`timescale 1ns/1ps
`include "dig_defines.svh"
module dig_host (
   input wire logic clk_in,
   input wire logic dut_oe_in,
   output logic scl_out,
   output logic sda_out
);
   logic drv_q = 1'b0;
   logic nak_q = 1'b0;
   logic [7:0] rb [0:4];
   initial scl_out = 1'b1;
   // open-drain wire with pull-up
   assign sda_out = ~(drv_q | dut_oe_in);
   task automatic gap();
      repeat (4) @(posedge clk_in);
   endtask : gap
   task automatic edge2(input logic a, input logic b);
      drv_q <= a;
      gap();
      scl_out <= 1'b1;
      gap();
      drv_q <= b;
      gap();
   endtask : edge2
   task automatic bitx(input logic b, output logic r);
      drv_q <= ~b;
      gap();
      scl_out <= 1'b1;
      gap();
      r = sda_out;
      scl_out <= 1'b0;
      gap();
   endtask : bitx
   task automatic octet(input logic [7:0] d, input logic a, input logic chk, output logic [7:0] q);
      logic ak;
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(a, ak);
      if (chk && ak) nak_q <= 1'b1;
   endtask : octet
   task automatic start();
      edge2(1'b0, 1'b1);
      scl_out <= 1'b0;
      gap();
   endtask : start
   task automatic wr(input logic [7:0] sub, input logic [7:0] d);
      logic [7:0] q;
      start();
      octet({`DIG_DEVICE_ADDR, 1'b0}, 1'b1, 1'b1, q);
      octet(sub, 1'b1, 1'b1, q);
      octet(d, 1'b1, 1'b1, q);
      edge2(1'b1, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] sub, input int n);
      logic [7:0] q;
      start();
      octet({`DIG_DEVICE_ADDR, 1'b0}, 1'b1, 1'b1, q);
      octet(sub, 1'b1, 1'b1, q);
      start();
      octet({`DIG_DEVICE_ADDR, 1'b1}, 1'b1, 1'b1, q);
      for (int i = 0; i < n; i++) octet(8'hff, i == n - 1, 1'b0, rb[i]);
      edge2(1'b1, 1'b0);
   endtask : rd
endmodule : dig_host

// [tb_dig_regs.sv]
`timescale 1ns/1ps
module tb_dig_regs;
   logic clk = 0, rst = 1, ls = 0, fs = 0, ec = 0, xc = 0, run = 0;
   int per = 0, ph = 0, lc = 0, err_count = 0, num_checks = 0, n = 0;
   int rc [0:2] = '{0, 0, 0};
   int d [0:2];
   logic [2:0] prv = 3'b000;
   wire scl, sda, oe, sdo, prim, sec, syn;
   wire [2:0] clp, rng;
   wire [7:0] lv1, lv2;
   wire [5:0] co;
   wire [4:0] fi;
   wire [2:0] ck = {syn, sec, prim};
   dig_regs u_dut (.ref_clk_in(clk), .rst_in(rst), .i2c_scl_in(scl), .i2c_sda_in(sda),
      .i2c_sda_out(sdo), .i2c_sda_oe_out(oe), .line_sync_in(ls), .frame_sync_in(fs),
      .external_converter_clock_in(ec), .ext_clamp_in(xc), .primary_converter_clock_out(prim),
      .second_converter_clock_out(sec), .synth_clock_out(syn), .chan_clamp_out(clp),
      .chan_clamp_range_out(rng), .chan1_clamp_level_value_out(lv1),
      .chan1_coarse_gain_value_out(co), .chan1_fine_gain_value_out(fi),
      .chan2_clamp_level_value_out(lv2));
   dig_host u_host (.clk_in(clk), .dut_oe_in(oe), .scl_out(scl), .sda_out(sda));
   always #5 clk = ~clk;
   // line sync every per cycles, frame sync rising every fifth line
   always @(posedge clk) begin
      ph <= (per == 0 || ph == per - 1) ? 0 : ph + 1;
      ls <= per != 0 && ph < 4;
      if (per != 0 && ph == 0) lc <= (lc == 4) ? 0 : lc + 1;
      fs <= per != 0 && lc == 0;
      if (run) ec <= ~ec;
      prv <= ck;
      for (int k = 0; k < 3; k++) if (ck[k] && !prv[k]) rc[k] <= rc[k] + 1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_n(input int c);
      repeat (c) @(posedge clk);
   endtask : wait_n
   task automatic rises(input int c);
      int a [0:2];
      a = rc;
      wait_n(c);
      for (int k = 0; k < 3; k++) d[k] = rc[k] - a[k];
   endtask : rises
   task automatic cnt();
      n = 0;
      repeat (per) begin
         @(posedge clk);
         n += (clp === 3'b111);
      end
   endtask : cnt
   task automatic t_reset();
      logic [15:0] tb [0:16] = '{16'h0f20, 16'h202a, 16'h2102, 16'h2200, 16'h2340, 16'h2400,
         16'h2580, 16'h2620, 16'h2710, 16'h2880, 16'h1416, 16'h158a, 16'h162e, 16'h17ba,
         16'h1800, 16'h1901, 16'h3f00};
      for (int i = 0; i < 17; i++) begin
         u_host.rd(tb[i][15:8], 1);
         chk(u_host.rb[0], tb[i][7:0]);
      end
      chk(lv1, 8'h80);
      chk(lv2, 8'h80);
      chk({2'h0, co}, 8'h20);
      chk({3'h0, fi}, 8'h10);
      chk({5'h0, rng}, 8'h00);
      chk({7'h0, u_host.nak_q}, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs();
      logic [7:0] v [0:3] = '{8'h5a, 8'h3f, 8'h1f, 8'ha5};
      for (int i = 0; i < 4; i++) u_host.wr(8'h25 + i[7:0], v[i]);
      u_host.rd(8'h25, 4);
      for (int i = 0; i < 4; i++) chk(u_host.rb[i], v[i]);
      chk(lv1, 8'h5a);
      chk({2'h0, co}, 8'h3f);
      chk({3'h0, fi}, 8'h1f);
      chk(lv2, 8'ha5);
      $display("test regs done");
   endtask : t_regs
   task automatic t_lines();
      per <= 300;
      wait_n(3600);
      u_host.rd(8'h10, 4);
      chk(u_host.rb[0], 8'h2c);
      chk(u_host.rb[1], 8'h01);
      chk(u_host.rb[2], 8'h05);
      chk(u_host.rb[3], 8'h00);
      u_host.rd(8'h19, 1);
      chk(u_host.rb[0], 8'h00);
      $display("test lines done");
   endtask : t_lines
   task automatic t_clamp();
      cnt();
      chk(n[7:0], 8'd62);
      u_host.wr(8'h21, 8'h10);
      u_host.wr(8'h23, 8'h20);
      cnt();
      chk(n[7:0], 8'd16);
      u_host.wr(8'h20, 8'h15);
      cnt();
      chk(n[7:0], 8'd0);
      chk({5'h0, rng}, 8'h07);
      u_host.wr(8'h20, 8'h6a);
      cnt();
      chk(n[7:0], 8'd0);
      xc <= 1'b1;
      wait_n(4);
      chk({5'h0, clp}, 8'h07);
      u_host.wr(8'h20, 8'h60);
      wait_n(4);
      chk({5'h0, clp}, 8'h01);
      xc <= 1'b0;
      u_host.wr(8'h20, 8'h2a);
      $display("test clamp done");
   endtask : t_clamp
   task automatic t_loop();
      logic [39:0] nom = 40'h00ba2e8a16;
      logic [7:0] ns [0:6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h03, 8'h04};
      u_host.wr(8'h0f, 8'h00);
      wait_n(3000);
      u_host.rd(8'h16, 1);
      chk({7'h0, u_host.rb[0] !== 8'h2e}, 8'h01);
      u_host.wr(8'h0f, 8'h20);
      for (int i = 0; i < 7; i++) u_host.wr(ns[i], nom[8 * ns[i] +: 8]);
      wait_n(600);
      u_host.rd(8'h14, 5);
      chk({7'h0, u_host.nak_q}, 8'h00);
      for (int i = 0; i < 5; i++) chk(u_host.rb[i], nom[8*i+:8]);
      $display("test loop done");
   endtask : t_loop
   task automatic t_clock();
      int f;
      per <= 0;
      rises(1000);
      f = d[2];
      chk({7'h0, d[0] - f <= 1 && f - d[0] <= 1}, 8'h01);
      u_host.wr(8'h0f, 8'h21);
      rises(1000);
      chk({7'h0, 2 * d[2] - f <= 2 && f - 2 * d[2] <= 2}, 8'h01);
      u_host.wr(8'h0f, 8'h30);
      ec <= 1'b1;
      wait_n(4);
      chk({6'h0, prim, sec}, 8'h03);
      u_host.wr(8'h0f, 8'h38);
      chk({6'h0, prim, sec}, 8'h02);
      u_host.wr(8'h0f, 8'h34);
      run <= 1'b1;
      rises(80);
      run <= 1'b0;
      chk({7'h0, 2 * d[1] - d[0] <= 2 && d[0] - 2 * d[1] <= 2}, 8'h01);
      $display("test clock done");
   endtask : t_clock
   task automatic t_miss();
      wait_n(4200);
      u_host.rd(8'h19, 1);
      chk(u_host.rb[0], 8'h01);
      $display("test miss done");
   endtask : t_miss
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   initial begin
      wait_n(80000);
      err_count++;
      end_of_test();
   end
   initial begin
      wait_n(12);
      rst <= 1'b0;
      wait_n(2);
      t_reset();
      t_regs();
      t_lines();
      t_clamp();
      t_loop();
      t_clock();
      t_miss();
      end_of_test();
   end
endmodule : tb_dig_regs
